// ---- rtl/idt_defines.vh ----
// Opcode, timing and layout constants for the instruction decode and timing block
`ifndef IDT_DEFINES_VH
`define IDT_DEFINES_VH
`define IDT_OP_SIGNED_PREFIX 8'hFE
`define IDT_OP_SHORT_RELATIVE_JUMP_BASE 5'h04
`define IDT_OP_SHORT_RELATIVE_CALL_BASE 5'h05
`define IDT_OP_JBC_BASE 5'h06
`define IDT_OP_JBS_BASE 5'h07
`define IDT_OP_LOOP 8'hE0
`define IDT_OP_RST 8'hFF
`define IDT_OP_CLRVT 8'hFC
`define IDT_OP_SHL 8'h09
`define IDT_OP_SHR 8'h08
`define IDT_OP_ARITHMETIC_RIGHT_SHIFT_OP 8'h0A
`define IDT_OP_SHLB 8'h19
`define IDT_OP_SHRB 8'h18
`define IDT_OP_SHRAB 8'h1A
`define IDT_OP_SHLL 8'h0D
`define IDT_OP_SHRL 8'h0C
`define IDT_OP_SHRAL 8'h0E
`define IDT_OP_NORMALIZE_OP 8'h0F
`define IDT_CJ_C 4'hB
`define IDT_CJ_NC 4'h3
`define IDT_CJ_E 4'hF
`define IDT_CJ_NE 4'h7
`define IDT_CJ_GE 4'h6
`define IDT_CJ_LT 4'hE
`define IDT_CJ_GT 4'h2
`define IDT_CJ_LE 4'hA
`define IDT_CJ_H 4'h9
`define IDT_CJ_NH 4'h1
`define IDT_CJ_V 4'hD
`define IDT_CJ_NV 4'h5
`define IDT_CJ_VT 4'hC
`define IDT_CJ_NVT 4'h4
`define IDT_CJ_ST 4'h8
`define IDT_CJ_NST 4'h0
`define IDT_CJ_HIGH 4'hD
`define IDT_ST_CJ_TAKEN 6'd8
`define IDT_ST_CJ_NOT 6'd4
`define IDT_ST_BIT_TAKEN 6'd9
`define IDT_ST_BIT_NOT 6'd5
`define IDT_ST_LOOP_TAKEN 6'd9
`define IDT_ST_LOOP_NOT 6'd5
`define IDT_ST_SHIFT_BASE 6'd7
`define IDT_ST_SHIFT_MIN 6'd8
`define IDT_ST_NORMALIZE_OP_BASE 6'd11
`define IDT_ST_RST_TOTAL 6'd16
`define IDT_ST_RST_PULL 6'd2
`define IDT_ST_RST_HOLD 6'd2
`define IDT_ST_RST_RUN 6'd12
`define IDT_ST_SIMPLE 6'd4
`define IDT_ST_IND_INT 6'd6
`define IDT_ST_IND_EXT 6'd11
`define IDT_ST_AUTOINC_EXTRA 6'd1
`define IDT_ST_SIGNED_EXTRA 6'd4
`define IDT_RESTART_ADDR 16'h2080
`define IDT_LEN_CJ 3'd2
`define IDT_LEN_BIT 3'd3
`define IDT_LEN_LOOP 3'd3
`define IDT_LEN_SHORT 3'd2
`define IDT_LEN_ONE 3'd1
`define IDT_LEN_THREE 3'd3
`endif

// ---- rtl/idt_state_timer.v ----
// State-time enable divider and countdown for the decode timing block
`timescale 1ns/100ps
module idt_state_timer #(
  parameter CLK_PER_STATE = 3,
  parameter DIV_W = 2
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire load,
  input wire [5:0] loadCount,
  output reg stateTick_r,
  output reg [5:0] remain_r
);
  reg [DIV_W-1:0] div_r;

  // One enable pulse per state time keeps a single clock domain
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= {DIV_W{1'b0}};
      stateTick_r <= 1'b0;
    end else if (div_r == CLK_PER_STATE[DIV_W-1:0] - 1'b1) begin
      div_r <= {DIV_W{1'b0}};
      stateTick_r <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      stateTick_r <= 1'b0;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      remain_r <= 6'd0;
    end else if (load) begin
      remain_r <= loadCount;
    end else if (stateTick_r && remain_r != 6'd0) begin
      remain_r <= remain_r - 6'd1;
    end
  end
endmodule // idt_state_timer

// ---- rtl/idt_decode_timing.v ----
// Instruction decode, branch predicates and state-time sequencing
`timescale 1ns/100ps
`include "idt_defines.vh"
// Operation
// - Byte-suffix opcode variants select byte size, long shifts double word, others word size.
// - Destination and second source come from registers; other source anywhere.
// - Relative displacements are signed two's complement added to the PC.
// - Short jump/call joins low three opcode bits with next byte: 11 bits.
// - Even second byte: indirect/short indexed; odd: auto-increment/long indexed.
// - Address register from second byte is word aligned; low bit ignored.
// - Signed multiply/divide is the unsigned opcode after prefix byte FE.
// - Indirect/indexed take fewer states for internal operands, e.g. 6/11.
// - Flag-conditional jumps are two bytes, 8 states taken, 4 not.
// - Bit jumps are three bytes, 9 states taken, 5 not.
// - Bit number from low opcode bits; 30-37 on clear, 38-3F on set.
// - Both trap jumps test the sticky trap flag then clear it.
// - Signed greater needs N and Z clear; complement when either set.
// - Unsigned higher needs C set and Z clear; complement otherwise.
// - Loop decrements operand, branches 8-bit when nonzero, 5/9 states.
// - Shifts take 7 plus one per bit, at least 8 states.
// - Long-suffix shifts operate on a 32-bit double word.
// - Reset: 2 states pulling low, 2 held, done in 12, restart 2080H.
// - Trap flag sets with overflow and stays until cleared or tested.
// - Right shift sets sticky flag when a one leaves through carry.
module idt_decode_timing #(
  parameter CLK_PER_STATE = 3,
  parameter DIV_W = 2
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire instStart,
  input wire [7:0] opByte,
  input wire [7:0] secondByte,
  input wire [7:0] thirdByte,
  input wire operandExternal,
  input wire [4:0] shiftCount,
  input wire [15:0] progCounter,
  input wire [15:0] loopOperand,
  input wire testedBitValue,
  input wire flagZero,
  input wire flagNeg,
  input wire flagCarry,
  input wire flagOvf,
  input wire ovfEvent,
  input wire shiftOutOne,
  input wire clearTrapCmd,
  output reg busy_r,
  output reg needPrefixNext_r,
  output reg signedOp_r,
  output reg [1:0] opSize_r,
  output reg autoIncLong_r,
  output reg [7:0] addrRegSel_r,
  output reg [7:0] dstRegSel_r,
  output reg [10:0] bitAddr_r,
  output reg [2:0] instLength_r,
  output reg [5:0] stateCount_r,
  output reg branchTaken_r,
  output reg [15:0] nextPc_r,
  output reg [15:0] loopResult_r,
  output reg loopWrite_r,
  output reg sticky_overflow_trap_flag_r,
  output reg sticky_shift_out_flag_r,
  output reg resetLineN_r,
  output reg fetchRestart_r
);
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_RESET = 2'd2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg prefixSeen_r;
  wire stateTick;
  wire [5:0] remain;
  reg timerLoad;
  reg [5:0] timerCount;

  wire opIsPrefix = (opByte == `IDT_OP_SIGNED_PREFIX);
  wire isCondJump = (opByte[7:4] == `IDT_CJ_HIGH);
  wire isShortRel = (opByte[7:3] == `IDT_OP_SHORT_RELATIVE_JUMP_BASE) || (opByte[7:3] == `IDT_OP_SHORT_RELATIVE_CALL_BASE);
  wire isBitClr = (opByte[7:3] == `IDT_OP_JBC_BASE);
  wire isBitSet = (opByte[7:3] == `IDT_OP_JBS_BASE);
  wire isLoop = (opByte == `IDT_OP_LOOP);
  wire isRst = (opByte == `IDT_OP_RST);
  wire isShiftWord = (opByte == `IDT_OP_SHL) || (opByte == `IDT_OP_SHR) ||
    (opByte == `IDT_OP_ARITHMETIC_RIGHT_SHIFT_OP);
  wire isShiftByte = (opByte == `IDT_OP_SHLB) || (opByte == `IDT_OP_SHRB) ||
    (opByte == `IDT_OP_SHRAB);
  wire isShiftLong = (opByte == `IDT_OP_SHLL) || (opByte == `IDT_OP_SHRL) ||
    (opByte == `IDT_OP_SHRAL);
  wire isNorml = (opByte == `IDT_OP_NORMALIZE_OP);
  wire isRightShift = (opByte == `IDT_OP_SHR) || (opByte == `IDT_OP_ARITHMETIC_RIGHT_SHIFT_OP) ||
    (opByte == `IDT_OP_SHRB) || (opByte == `IDT_OP_SHRAB) ||
    (opByte == `IDT_OP_SHRL) || (opByte == `IDT_OP_SHRAL);
  // Arithmetic/logic group from 0x40 to 0xCF, low two bits give the mode
  wire isAluGroup = (opByte[7:6] != 2'b00) && (opByte[7:4] < 4'hD) && !isLoop;
  wire isIndirect = isAluGroup && (opByte[1:0] == 2'b10);
  wire isIndexed = isAluGroup && (opByte[1:0] == 2'b11);
  wire byteVariant = (opByte[4] == 1'b1) && (opByte[7:6] != 2'b11);
  wire [15:0] loopDec = loopOperand - 16'd1;

  reg condMet;
  always @* begin
    case (opByte[3:0])
      `IDT_CJ_C: condMet = flagCarry;
      `IDT_CJ_NC: condMet = !flagCarry;
      `IDT_CJ_E: condMet = flagZero;
      `IDT_CJ_NE: condMet = !flagZero;
      `IDT_CJ_GE: condMet = !flagNeg;
      `IDT_CJ_LT: condMet = flagNeg;
      `IDT_CJ_GT: condMet = !flagNeg && !flagZero;
      `IDT_CJ_LE: condMet = flagNeg || flagZero;
      `IDT_CJ_H: condMet = flagCarry && !flagZero;
      `IDT_CJ_NH: condMet = !flagCarry || flagZero;
      `IDT_CJ_V: condMet = flagOvf;
      `IDT_CJ_NV: condMet = !flagOvf;
      `IDT_CJ_VT: condMet = sticky_overflow_trap_flag_r;
      `IDT_CJ_NVT: condMet = !sticky_overflow_trap_flag_r;
      `IDT_CJ_ST: condMet = sticky_shift_out_flag_r;
      `IDT_CJ_NST: condMet = !sticky_shift_out_flag_r;
      default: condMet = 1'b0;
    endcase
  end

  // Signed displacement forms, all sign extended to the PC width
  wire [15:0] disp8 = {{8{secondByte[7]}}, secondByte};
  wire [15:0] disp8Bit = {{8{thirdByte[7]}}, thirdByte};
  wire [15:0] disp11 = {{5{opByte[2]}}, opByte[2:0], secondByte};
  wire bitTaken = isBitClr ? !testedBitValue : testedBitValue;
  wire loopTaken = (loopDec != 16'd0);
  wire [5:0] shiftSum = `IDT_ST_SHIFT_BASE + {1'b0, shiftCount};
  wire [5:0] shiftStates = (shiftSum < `IDT_ST_SHIFT_MIN) ? `IDT_ST_SHIFT_MIN : shiftSum;
  wire [5:0] indBase = operandExternal ? `IDT_ST_IND_EXT : `IDT_ST_IND_INT;
  wire modeOdd = secondByte[0];

  idt_state_timer #(
    .CLK_PER_STATE(CLK_PER_STATE),
    .DIV_W(DIV_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(timerLoad),
    .loadCount(timerCount),
    .stateTick_r(stateTick),
    .remain_r(remain)
  );

  // Decode of the offered opcode, computed every cycle but used only on acceptance in idle
  reg [5:0] decStates;
  reg [2:0] decLen;
  reg decTaken;
  reg [15:0] decPc;
  always @* begin
    decStates = `IDT_ST_SIMPLE;
    decLen = `IDT_LEN_ONE;
    decTaken = 1'b0;
    decPc = progCounter + 16'd1;
    if (isCondJump) begin
      decLen = `IDT_LEN_CJ;
      decTaken = condMet;
      decStates = condMet ? `IDT_ST_CJ_TAKEN : `IDT_ST_CJ_NOT;
      decPc = progCounter + 16'd2 + (condMet ? disp8 : 16'd0);
    end else if (isBitClr || isBitSet) begin
      decLen = `IDT_LEN_BIT;
      decTaken = bitTaken;
      decStates = bitTaken ? `IDT_ST_BIT_TAKEN : `IDT_ST_BIT_NOT;
      decPc = progCounter + 16'd3 + (bitTaken ? disp8Bit : 16'd0);
    end else if (isLoop) begin
      decLen = `IDT_LEN_LOOP;
      decTaken = loopTaken;
      decStates = loopTaken ? `IDT_ST_LOOP_TAKEN : `IDT_ST_LOOP_NOT;
      decPc = progCounter + 16'd3 + (loopTaken ? disp8Bit : 16'd0);
    end else if (isShortRel) begin
      decLen = `IDT_LEN_SHORT;
      decTaken = 1'b1;
      decStates = `IDT_ST_CJ_TAKEN;
      decPc = progCounter + 16'd2 + disp11;
    end else if (isShiftWord || isShiftByte || isShiftLong) begin
      decLen = `IDT_LEN_THREE;
      decStates = shiftStates;
      decPc = progCounter + 16'd3;
    end else if (isNorml) begin
      decLen = `IDT_LEN_THREE;
      decStates = `IDT_ST_NORMALIZE_OP_BASE + {1'b0, shiftCount};
      decPc = progCounter + 16'd3;
    end else if (isRst) begin
      decStates = `IDT_ST_RST_TOTAL;
      decPc = `IDT_RESTART_ADDR;
    end else if (isIndirect || isIndexed) begin
      decLen = `IDT_LEN_THREE;
      decStates = indBase + (modeOdd ? `IDT_ST_AUTOINC_EXTRA : 6'd0);
      decPc = progCounter + 16'd3;
    end
    if (prefixSeen_r) begin
      decLen = decLen + 3'd1;
      decStates = decStates + `IDT_ST_SIGNED_EXTRA;
    end
  end

  always @* begin
    state_nxt = state_r;
    timerLoad = 1'b0;
    timerCount = 6'd0;
    case (state_r)
      ST_IDLE: begin
        if (instStart && !opIsPrefix) begin
          timerLoad = 1'b1;
          timerCount = isRst ? `IDT_ST_RST_TOTAL : decStates;
          state_nxt = isRst ? ST_RESET : ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (stateTick && remain == 6'd1)
          state_nxt = ST_IDLE;
      end
      ST_RESET: begin
        if (stateTick && remain == 6'd1)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire accept = (state_r == ST_IDLE) && instStart;
  wire acceptOp = accept && !opIsPrefix;
  // States elapsed in reset: line low after the pull phase, until the run phase
  wire [5:0] rstElapsed = `IDT_ST_RST_TOTAL - remain;
  wire rstLow = (state_r == ST_RESET) && (rstElapsed >= `IDT_ST_RST_PULL) &&
    (rstElapsed < `IDT_ST_RST_PULL + `IDT_ST_RST_HOLD);
  wire trapClear = (acceptOp && isCondJump &&
    (opByte[3:0] == `IDT_CJ_VT || opByte[3:0] == `IDT_CJ_NVT)) ||
    (acceptOp && opByte == `IDT_OP_CLRVT) || clearTrapCmd;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      prefixSeen_r <= 1'b0;
      busy_r <= 1'b0;
      needPrefixNext_r <= 1'b0;
      signedOp_r <= 1'b0;
      opSize_r <= 2'd1;
      autoIncLong_r <= 1'b0;
      addrRegSel_r <= 8'h00;
      dstRegSel_r <= 8'h00;
      bitAddr_r <= 11'h000;
      instLength_r <= 3'd0;
      stateCount_r <= 6'd0;
      branchTaken_r <= 1'b0;
      nextPc_r <= 16'h0000;
      loopResult_r <= 16'h0000;
      loopWrite_r <= 1'b0;
      sticky_overflow_trap_flag_r <= 1'b0;
      sticky_shift_out_flag_r <= 1'b0;
      resetLineN_r <= 1'b1;
      fetchRestart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      resetLineN_r <= !rstLow;
      loopWrite_r <= acceptOp && isLoop;
      fetchRestart_r <= (state_r == ST_RESET) && (state_nxt == ST_IDLE);
      // Set wins over clear so a fresh overflow is never lost
      if (ovfEvent)
        sticky_overflow_trap_flag_r <= 1'b1;
      else if (trapClear)
        sticky_overflow_trap_flag_r <= 1'b0;
      if (acceptOp && isRightShift)
        sticky_shift_out_flag_r <= shiftOutOne;
      if (accept && opIsPrefix) begin
        prefixSeen_r <= 1'b1;
        needPrefixNext_r <= 1'b1;
      end else if (acceptOp) begin
        prefixSeen_r <= 1'b0;
        needPrefixNext_r <= 1'b0;
        signedOp_r <= prefixSeen_r;
        if (isShiftLong)
          opSize_r <= 2'd2;
        else if (isShiftByte || byteVariant)
          opSize_r <= 2'd0;
        else
          opSize_r <= 2'd1;
        autoIncLong_r <= (isIndirect || isIndexed) && modeOdd;
        addrRegSel_r <= {secondByte[7:1], 1'b0};
        dstRegSel_r <= isAluGroup ? thirdByte : secondByte;
        bitAddr_r <= {secondByte, opByte[2:0]};
        instLength_r <= decLen;
        stateCount_r <= isRst ? `IDT_ST_RST_TOTAL : decStates;
        branchTaken_r <= decTaken;
        nextPc_r <= decPc;
        if (isLoop)
          loopResult_r <= loopDec;
      end
    end
  end
endmodule // idt_decode_timing

// ---- sim/idt_dt_asserts.sv ----
// Concurrent checks on the ports of the decode timing block
`timescale 1ns/100ps
module idt_dt_asserts (
  input wire sys_clk,
  input wire sys_rst,
  input wire instStart,
  input wire [7:0] opByte,
  input wire [4:0] shiftCount,
  input wire [15:0] loopOperand,
  input wire testedBitValue,
  input wire flagZero,
  input wire flagNeg,
  input wire flagCarry,
  input wire ovfEvent,
  input wire shiftOutOne,
  input wire busy_r,
  input wire needPrefixNext_r,
  input wire [2:0] instLength_r,
  input wire [5:0] stateCount_r,
  input wire branchTaken_r,
  input wire [15:0] nextPc_r,
  input wire [15:0] loopResult_r,
  input wire sticky_overflow_trap_flag_r,
  input wire sticky_shift_out_flag_r,
  input wire resetLineN_r,
  input wire fetchRestart_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire plain = instStart && !busy_r && !needPrefixNext_r;
  // Counts assume 3 clocks a state; the free-running tick phase adds up to one state
  sequence rstPull; ##[1:12] !resetLineN_r; endsequence
  sequence rstHold; !resetLineN_r [*6]; endsequence
  cj_time_a: assert property (plain && opByte[7:4] == 4'hD |=>
    instLength_r == 3'd2 && stateCount_r == (branchTaken_r ? 6'd8 : 6'd4))
    else $error("conditional jump length or time wrong");
  bit_time_a: assert property (plain && opByte[7:4] == 4'h3 |=>
    instLength_r == 3'd3 && branchTaken_r == ($past(testedBitValue) == $past(opByte[3]))
    && stateCount_r == (branchTaken_r ? 6'd9 : 6'd5)) else $error("bit jump wrong");
  signed_gt_a: assert property (plain && opByte == 8'hD2 |=>
    branchTaken_r == !($past(flagNeg) || $past(flagZero))) else $error("greater test wrong");
  unsigned_hi_a: assert property (plain && opByte == 8'hD9 |=>
    branchTaken_r == ($past(flagCarry) && !$past(flagZero))) else $error("higher test wrong");
  trap_clear_a: assert property (plain && opByte[7:4] == 4'hD && opByte[2:0] == 3'd4
    && !ovfEvent |=> !sticky_overflow_trap_flag_r) else $error("trap jump left flag set");
  trap_set_a: assert property (ovfEvent |=> sticky_overflow_trap_flag_r)
    else $error("overflow did not set trap flag");
  shift_min_a: assert property (plain && opByte == 8'h09 |=> stateCount_r ==
    ($past(shiftCount) == 5'd0 ? 6'd8 : 6'd7 + {1'b0, $past(shiftCount)}))
    else $error("shift time wrong");
  loop_dec_a: assert property (plain && opByte == 8'hE0 |=>
    loopResult_r == $past(loopOperand) - 16'h0001 && branchTaken_r == (loopResult_r != 16'h0000)
    && stateCount_r == (branchTaken_r ? 6'd9 : 6'd5)) else $error("loop step wrong");
  sticky_shift_a: assert property (plain && opByte == 8'h08 |=>
    sticky_shift_out_flag_r == $past(shiftOutOne)) else $error("sticky shift flag wrong");
  prefix_wait_a: assert property (plain && opByte == 8'hFE |=> needPrefixNext_r)
    else $error("prefix not held");
  rst_pull_a: assert property (plain && opByte == 8'hFF |-> rstPull)
    else $error("reset line not pulled");
  rst_hold_a: assert property ($fell(resetLineN_r) |-> rstHold ##[1:40] fetchRestart_r)
    else $error("reset hold or restart wrong");
  restart_addr_a: assert property (fetchRestart_r |-> nextPc_r == 16'h2080)
    else $error("restart address wrong");
endmodule // idt_dt_asserts
bind idt_decode_timing idt_dt_asserts i_chk (.*);

// ---- sim/idt_prog_mem.sv ----
// Program memory model feeding instruction bytes to the decoder
`timescale 1ns/100ps
module idt_prog_mem (
  input wire [15:0] progCounter,
  output logic [7:0] opByte,
  output logic [7:0] secondByte,
  output logic [7:0] thirdByte
);
  logic [7:0] mem [0:255];
  // Filled with a no-operation so the decoder never sees unknown bytes at start
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFD;
  // Only 256 bytes: the high address bits alias, which is enough for decode
  always_comb begin
    opByte = mem[progCounter[7:0]];
    secondByte = mem[progCounter[7:0] + 8'h01];
    thirdByte = mem[progCounter[7:0] + 8'h02];
  end
endmodule // idt_prog_mem

// ---- sim/testbench.sv ----
// Random and corner stimulus bench for the decode timing block
`timescale 1ns/100ps
module testbench;
  logic sys_clk, sys_rst, instStart, operandExternal, testedBitValue, flagZero, flagNeg;
  logic flagCarry, flagOvf, ovfEvent, shiftOutOne, clearTrapCmd, busy_r, needPrefixNext_r;
  logic signedOp_r, autoIncLong_r, branchTaken_r, loopWrite_r, resetLineN_r, fetchRestart_r;
  logic sticky_overflow_trap_flag_r, sticky_shift_out_flag_r, eTake, eVt, eSf, ePre;
  logic [7:0] opByte, secondByte, thirdByte, addrRegSel_r, dstRegSel_r;
  logic [4:0] shiftCount;
  logic [15:0] progCounter, loopOperand, nextPc_r, loopResult_r, ePc;
  logic [1:0] opSize_r;
  logic [10:0] bitAddr_r;
  logic [2:0] instLength_r, eLen, eCls;
  logic [5:0] stateCount_r, eSt;
  logic [31:0] seed = 32'hFC33C06F;
  logic [7:0] ops [8] = '{8'hE0, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h66, 8'h76, 8'hE0};
  int fail_count = 0;
  int n_tests = 0;
  idt_decode_timing i_dut (.*);
  idt_prog_mem i_mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected result at %0t: op %h got %h want %h", $time, opByte, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Expectations from the flags in force when the opcode is offered
  function automatic void predict(input logic [7:0] op, b2, b3);
    logic [7:0] f;
    logic [15:0] d;
    f = {flagZero, flagNeg, flagOvf, eVt, flagCarry, flagNeg | flagZero, flagCarry & ~flagZero, eSf};
    d = {{8{b3[7]}}, b3};
    eCls = 3'd0;
    eLen = 3'd3;
    eSt = 6'd0;
    eTake = 1'b1;
    if (op[7:4] == 4'hD) begin
      eCls = 3'd1;
      eLen = 3'd2;
      eTake = f[op[2:0]] == op[3];
      eSt = eTake ? 6'd8 : 6'd4;
      d = {{8{b2[7]}}, b2};
      if (op[2:0] == 3'd4) eVt = 1'b0;
    end else if (op[7:4] == 4'h3 || op == 8'hE0) begin
      eCls = 3'd1;
      eTake = op == 8'hE0 ? loopOperand != 16'h0001 : testedBitValue == op[3];
      eSt = eTake ? 6'd9 : 6'd5;
    end else if (op[7:4] == 4'h2) begin
      eCls = 3'd1;
      eLen = 3'd2;
      d = {{5{op[2]}}, op[2:0], b2};
    end else if (op[7:4] == 4'h0) begin
      eSt = shiftCount == 5'd0 ? 6'd8 : 6'd7 + {1'b0, shiftCount};
      if (op != 8'h09) eSf = shiftOutOne;
    end else if (op == 8'h66 || op == 8'h76) begin
      eCls = 3'd2;
      eSt = (operandExternal ? 6'd11 : 6'd6) + {5'd0, b2[0]};
    end else eLen = 3'd0;
    ePc = progCounter + {13'd0, eLen} + (eTake ? d : 16'h0000);
  endfunction
  task automatic issue(input logic [7:0] op);
    int n;
    int nLow;
    logic [31:0] r;
    logic [31:0] b;
    logic saw;
    n = 0;
    nLow = 0;
    saw = 1'b0;
    r = rnd();
    b = rnd();
    @(posedge sys_clk);
    i_mem.mem[r[7:0]] <= op;
    i_mem.mem[r[7:0] + 8'd1] <= b[7:0];
    i_mem.mem[r[7:0] + 8'd2] <= b[15:8];
    progCounter <= r[15:0];
    {flagZero, flagNeg, flagCarry, flagOvf, testedBitValue, shiftOutOne, operandExternal} <= r[22:16];
    shiftCount <= r[23] ? 5'd0 : b[28:24];
    loopOperand <= r[29] ? 16'h0001 : (r[30] ? 16'h0000 : b[31:16]);
    clearTrapCmd <= 1'b0;
    instStart <= 1'b1;
    #1;
    predict(op, b[7:0], b[15:8]);
    @(posedge sys_clk);
    instStart <= 1'b0;
    #1;
    chk(needPrefixNext_r, op == 8'hFE);
    if (op != 8'hFE) chk(signedOp_r, ePre);
    if (eLen != 3'd0) chk(instLength_r, eLen);
    if (eSt != 6'd0) chk(stateCount_r, eSt);
    if (eCls == 3'd1) chk(branchTaken_r, eTake);
    if (eCls == 3'd1) chk(nextPc_r, ePc);
    if (eCls == 3'd2) chk({addrRegSel_r, autoIncLong_r, opSize_r}, {b[7:1], 1'b0, b[0], 1'b0, ~op[4]});
    if (eCls == 3'd2) chk(dstRegSel_r, b[15:8]);
    chk(loopWrite_r, op == 8'hE0);
    if (op[7:4] == 4'h3) chk(bitAddr_r, {b[7:0], op[2:0]});
    if (op == 8'h0C) chk(opSize_r, 2'd2);
    ePre = op == 8'hFE;
    // The restart pulse rises on the same edge that the busy flag falls; a reset also waits until it is seen
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      nLow += !resetLineN_r;
      saw |= fetchRestart_r === 1'b1;
    end while ((busy_r === 1'b1 || (op == 8'hFF && !saw)) && n < 300);
    if (eSt != 6'd0) chk(n >= 3 * eSt - 3 && n <= 3 * eSt + 4, 1'b1);
    if (op != 8'hFF) chk({sticky_overflow_trap_flag_r, sticky_shift_out_flag_r}, {eVt, eSf});
    if (op == 8'hFF) chk(nLow, 6);
    if (op == 8'hFF) chk(nextPc_r, 16'h2080);
  endtask
  // About 230 instructions of at most 38 states each fit well inside this span
  initial begin
    #1000000;
    fail_count++;
    stop_test();
  end
  initial begin
    {instStart, operandExternal, testedBitValue, flagZero, flagNeg, flagCarry, flagOvf} = '0;
    {ovfEvent, shiftOutOne, clearTrapCmd, shiftCount, progCounter, loopOperand} = '0;
    {sys_rst, eVt, eSf, ePre} = 4'h8;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 64; i++) issue(8'hD0 + 8'(i % 16));
    for (int i = 0; i < 96; i++) issue(8'h20 + 8'(i % 32));
    for (int i = 0; i < 64; i++) issue(ops[i % 8]);
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      ovfEvent <= 1'b1;
      @(posedge sys_clk);
      ovfEvent <= 1'b0;
      clearTrapCmd <= k == 2;
      eVt = k < 2;
      issue(k == 0 ? 8'hDC : (k == 1 ? 8'hD4 : 8'hD0));
    end
    for (int i = 0; i < 4; i++) issue(i % 2 == 0 ? 8'hFE : (i == 1 ? 8'h6C : 8'h8C));
    issue(8'hFF);
    stop_test();
  end
endmodule // testbench
